// File: src/bsci_mem.sv
// Burst SRAM input stage with a small storage array behind it.
// Assumes pins come from logic on clk_sys; no synchroniser needed.
// Summary of operation
// - Address captured on rising edge.
// - Active-low lane selects qualify writes.
// - Each select guards one byte and parity.
// - Write request sampled only while qualified.
// - Controller drives write request low to write.
// - Advance high steps burst counter.
// - Advance low loads presented address.
// - Controller loads after deselect, never advances.
// - Unqualified edges hold all state.
// - Selected when cs1 low, cs2 high, cs3 low.
// - Data drivers off on write and deselect.
`default_nettype none
module bsci_mem
   import bsci_pkg::*;
   #(
      parameter int DEPTH_P = DEPTH
   ) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins
   bsci_if.mem pins,
   // Status
   output logic selected,
   output logic burst_invalid
   );

   if (DEPTH_P < 4 || DEPTH_P > (1 << ADDR_W)) begin : g_depth_chk
      $error("bsci_mem: DEPTH_P out of range");
   end

   localparam int IDX_W = $clog2(DEPTH_P);

   logic [DATA_W-1:0] store [DEPTH_P];
   logic [ADDR_W-1:0] base_addr;
   logic [1:0] burst_cnt;
   logic op_write;
   logic op_active;
   logic was_deselected;
   logic wr_phase;
   logic rd_phase;
   logic issue;
   logic op_w_now;
   logic [ADDR_W-1:0] issue_addr;
   logic [LANES-1:0] wr_lanes;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] rd_data;
   logic [ADDR_W-1:0] cur_addr;
   logic [ADDR_W-1:0] next_addr;
   logic qualified;
   logic chip_sel;

   function automatic logic [1:0] burst_step(input logic [1:0] start,
         input logic [1:0] cnt, input logic ilv);
      burst_step = ilv ? (start ^ cnt) : 2'(start + cnt);
   endfunction

   assign qualified = !pins.clock_qualify_n;
   assign chip_sel = !pins.chip_select_one_n && pins.chip_select_two
      && !pins.chip_select_three_n;
   assign cur_addr = {base_addr[ADDR_W-1:2],
      burst_step(base_addr[1:0], burst_cnt,
      pins.burst_order_interleaved)};
   assign next_addr = {base_addr[ADDR_W-1:2],
      burst_step(base_addr[1:0], 2'(burst_cnt + 2'h1),
      pins.burst_order_interleaved)};

   // Command capture: load or advance
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         base_addr <= '0;
         burst_cnt <= BURST_START;
         op_write <= 1'b0;
         op_active <= 1'b0;
         was_deselected <= 1'b1;
         burst_invalid <= 1'b0;
         selected <= 1'b0;
      end else if (qualified) begin
         burst_invalid <= 1'b0;
         if (!pins.advance_or_load) begin
            selected <= chip_sel;
            if (chip_sel) begin
               base_addr <= pins.addr;
               burst_cnt <= BURST_START;
               op_write <= !pins.write_request_n;
               op_active <= 1'b1;
               was_deselected <= 1'b0;
            end else begin
               op_active <= 1'b0;
               was_deselected <= 1'b1;
            end
         end else if (was_deselected) begin
            burst_invalid <= 1'b1;
            op_active <= 1'b0;
         end else begin
            burst_cnt <= 2'(burst_cnt + 2'h1);
            op_active <= 1'b1;
         end
      end
   end

   // Pipeline stage into the data phase
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_phase <= 1'b0;
         rd_phase <= 1'b0;
         wr_lanes <= '0;
         wr_addr <= '0;
      end else if (qualified) begin
         wr_phase <= issue && op_w_now;
         rd_phase <= issue && !op_w_now;
         wr_lanes <= ~pins.byte_lane_write_select_n;
         wr_addr <= issue_addr;
      end
   end

   always_comb begin
      issue = 1'b0;
      op_w_now = op_write;
      issue_addr = next_addr;
      if (!pins.advance_or_load) begin
         issue = chip_sel;
         op_w_now = !pins.write_request_n;
         issue_addr = pins.addr;
      end else if (!was_deselected) begin
         issue = 1'b1;
      end
   end

   // Byte-lane masked write into the array
   always_ff @(posedge clk_sys) begin
      if (qualified && wr_phase) begin
         for (int l = 0; l < LANES; l++) begin
            if (wr_lanes[l])
               store[IDX_W'(wr_addr)][l*LANE_W +: LANE_W] <=
                  pins.dq_from_ctrl[l*LANE_W +: LANE_W];
         end
      end
   end

   // Read data and driver enable
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (qualified && issue && !op_w_now) begin
         rd_data <= store[IDX_W'(issue_addr)];
      end
   end

   assign pins.dq_from_mem = rd_data;
   // Read data phase only; the command cycle after deselect stays off
   assign pins.dq_mem_oe = rd_phase && !wr_phase
      && !pins.output_enable_n && op_active;

endmodule
`default_nettype wire

// File: src/bsci_pkg.sv
// Package for the burst SRAM command input stage and its controller.
// Assumes both ends share clk_sys and rst_n.
`default_nettype none
package bsci_pkg;
   localparam int ADDR_W = 20;
   localparam int LANES = 8;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int DEPTH = 64;
   localparam logic [1:0] BURST_START = 2'h0;
   typedef enum logic [1:0] {
      BSCI_OP_IDLE,
      BSCI_OP_READ,
      BSCI_OP_WRITE,
      BSCI_OP_BURST
   } bsci_op_t;
endpackage
`default_nettype wire

// File: src/bsci_if.sv
// Pin bundle between the memory controller and the SRAM input stage.
// Assumes one shared clock; each data direction has its own wire and its own enable.
`default_nettype none
interface bsci_if
   import bsci_pkg::*;
   ();
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0] byte_lane_write_select_n;
   logic write_request_n;
   logic advance_or_load;
   logic clock_qualify_n;
   logic chip_select_one_n;
   logic chip_select_two;
   logic chip_select_three_n;
   logic output_enable_n;
   logic burst_order_interleaved;
   logic [DATA_W-1:0] dq_from_ctrl;
   logic dq_ctrl_oe;
   logic [DATA_W-1:0] dq_from_mem;
   logic dq_mem_oe;
   modport mem (
      input addr, byte_lane_write_select_n, write_request_n,
      input advance_or_load, clock_qualify_n, chip_select_one_n,
      input chip_select_two, chip_select_three_n, output_enable_n,
      input burst_order_interleaved, dq_from_ctrl, dq_ctrl_oe,
      output dq_from_mem, dq_mem_oe
   );
   modport ctrl (
      output addr, byte_lane_write_select_n, write_request_n,
      output advance_or_load, clock_qualify_n, chip_select_one_n,
      output chip_select_two, chip_select_three_n, output_enable_n,
      output burst_order_interleaved, dq_from_ctrl, dq_ctrl_oe,
      input dq_from_mem, dq_mem_oe
   );
endinterface
`default_nettype wire

// File: src/bsci_ctrl.sv
// Memory controller end that drives the SRAM command pins.
// Assumes the SRAM samples pins on the same clk_sys edge.
`default_nettype none
module bsci_ctrl
   import bsci_pkg::*;
   (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins
   bsci_if.ctrl pins,
   // User request
   input wire logic req_valid,
   input wire bsci_op_t req_op,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [LANES-1:0] req_lanes,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic req_hold,
   input wire logic req_interleaved,
   output logic req_ready,
   // Read answer
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_data
   );

   logic selected;
   logic last_write;
   logic rd_pipe;
   logic [DATA_W-1:0] wdata_q;
   logic wpend;
   bsci_op_t op_eff;

   // Burst after deselect is turned into an idle cycle
   always_comb begin
      op_eff = req_valid ? req_op : BSCI_OP_IDLE;
      if (op_eff == BSCI_OP_BURST && !selected)
         op_eff = BSCI_OP_IDLE;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pins.addr <= '0;
         pins.byte_lane_write_select_n <= '1;
         pins.write_request_n <= 1'b1;
         pins.advance_or_load <= 1'b0;
         pins.clock_qualify_n <= 1'b1;
         pins.chip_select_one_n <= 1'b1;
         pins.chip_select_two <= 1'b0;
         pins.chip_select_three_n <= 1'b1;
         pins.output_enable_n <= 1'b1;
         pins.burst_order_interleaved <= 1'b0;
         selected <= 1'b0;
         last_write <= 1'b0;
         wdata_q <= '0;
         wpend <= 1'b0;
         req_ready <= 1'b0;
      end else begin
         req_ready <= !req_hold;
         pins.clock_qualify_n <= req_hold;
         pins.output_enable_n <= 1'b0;
         pins.burst_order_interleaved <= req_interleaved;
         if (!req_hold) begin
            wpend <= 1'b0;
            unique case (op_eff)
               BSCI_OP_IDLE: begin
                  pins.advance_or_load <= 1'b0;
                  pins.chip_select_one_n <= 1'b1;
                  selected <= 1'b0;
               end
               BSCI_OP_BURST: begin
                  pins.advance_or_load <= 1'b1;
                  pins.byte_lane_write_select_n <= ~req_lanes;
                  wdata_q <= req_wdata;
                  wpend <= last_write;
               end
               BSCI_OP_READ, BSCI_OP_WRITE: begin
                  pins.advance_or_load <= 1'b0;
                  pins.addr <= req_addr;
                  pins.chip_select_one_n <= 1'b0;
                  pins.chip_select_two <= 1'b1;
                  pins.chip_select_three_n <= 1'b0;
                  pins.write_request_n <= op_eff != BSCI_OP_WRITE;
                  pins.byte_lane_write_select_n <= ~req_lanes;
                  last_write <= op_eff == BSCI_OP_WRITE;
                  wdata_q <= req_wdata;
                  wpend <= op_eff == BSCI_OP_WRITE;
                  selected <= 1'b1;
               end
            endcase
         end
      end
   end

   // Data phase one qualified cycle after the command
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pins.dq_from_ctrl <= '0;
         pins.dq_ctrl_oe <= 1'b0;
      end else if (!pins.clock_qualify_n) begin
         pins.dq_from_ctrl <= wdata_q;
         pins.dq_ctrl_oe <= wpend;
      end
   end

   // Read data returns two qualified edges after the command
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_pipe <= '0;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (!pins.clock_qualify_n) begin
            rd_pipe <= (pins.chip_select_one_n == 1'b0
               || pins.advance_or_load) && selected && !last_write;
            rsp_valid <= rd_pipe;
            rsp_data <= pins.dq_from_mem;
         end
      end
   end

endmodule
`default_nettype wire

// File: sim/bsci_props.sv
// Checker on the pins between the controller and the SRAM input stage.
// Assumes one clock; instantiated beside the interface, no bind.
`default_nettype none
module bsci_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins
   input wire logic write_request_n,
   input wire logic advance_or_load,
   input wire logic clock_qualify_n,
   input wire logic chip_select_one_n,
   input wire logic chip_select_two,
   input wire logic chip_select_three_n,
   input wire logic output_enable_n,
   input wire logic dq_ctrl_oe,
   input wire logic dq_mem_oe,
   // Status
   input wire logic selected,
   input wire logic burst_invalid
   );
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic cs_ok;
   logic go;
   assign cs_ok = !chip_select_one_n && chip_select_two;
   assign go = !clock_qualify_n;
   a_select_decode: assert property (
      go |=> selected == $past(cs_ok && !chip_select_three_n))
      else $error("selected does not follow the chip selects");
   a_hold_state: assert property (
      clock_qualify_n |=> $stable(selected) && $stable(dq_mem_oe))
      else $error("state moved on an unqualified edge");
   a_no_clash: assert property (dq_ctrl_oe |-> !dq_mem_oe)
      else $error("memory drives data during a write");
   a_desel_quiet: assert property ((go && !selected) [*3] |-> !dq_mem_oe)
      else $error("memory drives data while deselected");
   a_burst_flag: assert property (
      go && advance_or_load && !selected && cs_ok && !chip_select_three_n
      |=> burst_invalid) else $error("advance after deselect not flagged");
   a_flag_cause: assert property (
      burst_invalid |-> $past(go && advance_or_load && !selected))
      else $error("burst flag without a deselected advance");
   a_write_data: assert property (
      go && cs_ok && !chip_select_three_n && !write_request_n &&
      !advance_or_load |-> ##[1:2] dq_ctrl_oe)
      else $error("write data not driven after a write");
   a_read_drive: assert property (
      go && cs_ok && !chip_select_three_n && write_request_n &&
      !advance_or_load && !output_enable_n |-> ##[1:3] dq_mem_oe)
      else $error("read data not driven after a read");
endmodule
`default_nettype wire

// File: sim/tb_burst_sram_command_inputs.sv
// Bench joining controller and SRAM stage, plus a bench-driven second port.
// Assumes the design files of src/ are compiled first.
`default_nettype none
module tb_burst_sram_command_inputs
   import bsci_pkg::*;
   ();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   bsci_op_t req_op = BSCI_OP_IDLE;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [LANES-1:0] req_lanes = '0;
   logic [DATA_W-1:0] req_wdata = '0;
   logic req_hold = 1'b0;
   logic req_interleaved = 1'b0;
   logic rsp_valid, selected, burst_invalid, sel2, inv2;
   logic [DATA_W-1:0] rsp_data;
   logic [DATA_W-1:0] got[$];
   logic [DATA_W-1:0] want[$];
   int fails = 0;
   int n_compared = 0;
   bsci_if bus ();
   bsci_if bus2 ();
   always #4 clk_sys = ~clk_sys;
   bsci_mem u_bsci_mem (.clk_sys(clk_sys), .rst_n(rst_n), .pins(bus.mem),
      .selected(selected), .burst_invalid(burst_invalid));
   bsci_mem u_bsci_mem_2 (.clk_sys(clk_sys), .rst_n(rst_n),
      .pins(bus2.mem), .selected(sel2), .burst_invalid(inv2));
   bsci_ctrl u_bsci_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .pins(bus.ctrl),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
      .req_lanes(req_lanes), .req_wdata(req_wdata), .req_hold(req_hold),
      .req_interleaved(req_interleaved), .req_ready(),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   bsci_props u_bsci_props (.clk_sys(clk_sys), .rst_n(rst_n),
      .write_request_n(bus.write_request_n),
      .advance_or_load(bus.advance_or_load),
      .clock_qualify_n(bus.clock_qualify_n),
      .chip_select_one_n(bus.chip_select_one_n),
      .chip_select_two(bus.chip_select_two),
      .chip_select_three_n(bus.chip_select_three_n),
      .output_enable_n(bus.output_enable_n), .dq_ctrl_oe(bus.dq_ctrl_oe),
      .dq_mem_oe(bus.dq_mem_oe), .selected(selected),
      .burst_invalid(burst_invalid));
   always @(posedge clk_sys) begin
      if (rsp_valid === 1'b1) begin
         got.push_back(rsp_data);
      end
   end
   function automatic logic [DATA_W-1:0] pat(input int a);
      return {LANES{LANE_W'(a)}};
   endfunction
   task automatic chk(input logic [DATA_W-1:0] g, e, input string m);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic rq(input bsci_op_t op, input int a, input int l = 255,
         input logic [DATA_W-1:0] d = '0, input logic h = 1'b0);
      @(negedge clk_sys);
      req_valid = 1'b1;
      req_op = op;
      req_addr = ADDR_W'(a);
      req_lanes = LANES'(l);
      req_wdata = d;
      req_hold = h;
      @(posedge clk_sys);
   endtask
   task automatic idle(input int n);
      repeat (n) rq(BSCI_OP_IDLE, 0);
   endtask
   task automatic drain();
      for (int i = 0; i < 60 && got.size() < want.size(); i++) begin
         @(posedge clk_sys);
      end
      chk(got.size(), want.size(), "response count");
      while (got.size() > 0 && want.size() > 0) begin
         chk(got.pop_front(), want.pop_front(), "read data");
      end
      got.delete();
      want.delete();
   endtask
   task automatic wrap_up();
      $display("Compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      wrap_up();
   end
   initial begin
      // Second port starts deselected and unqualified
      {bus2.write_request_n, bus2.advance_or_load, bus2.clock_qualify_n,
       bus2.chip_select_one_n, bus2.chip_select_two,
       bus2.chip_select_three_n, bus2.output_enable_n,
       bus2.burst_order_interleaved, bus2.dq_ctrl_oe} = 9'h174;
      bus2.addr = '0;
      bus2.byte_lane_write_select_n = '1;
      bus2.dq_from_ctrl = '0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      rq(BSCI_OP_WRITE, 6, 255, pat(1));
      rq(BSCI_OP_WRITE, 6, 15, pat(2));
      #1 chk(bus.byte_lane_write_select_n, 8'hF0, "lane pins");
      idle(3);
      rq(BSCI_OP_READ, 6);
      want.push_back((pat(1) & ~DATA_W'({4 * LANE_W{1'b1}}))
         | (pat(2) & DATA_W'({4 * LANE_W{1'b1}})));
      idle(3);
      drain();
      for (int a = 8; a < 12; a++) rq(BSCI_OP_WRITE, a, 255, pat(a));
      for (int m = 0; m < 2; m++) begin
         idle(2);
         @(negedge clk_sys);
         req_interleaved = m[0];
         rq(BSCI_OP_READ, 9);
         want.push_back(pat(9));
         for (int k = 1; k < 4; k++) begin
            if (k == 3) repeat (3) rq(BSCI_OP_BURST, 0, 255, '0, 1'b1);
            rq(BSCI_OP_BURST, 0);
            want.push_back(pat(m ? 9 ^ k : 8 + ((9 + k) & 3)));
         end
         idle(3);
         drain();
      end
      rq(BSCI_OP_BURST, 0);
      idle(4);
      drain();
      @(negedge clk_sys);
      bus2.chip_select_one_n = 1'b0;
      @(negedge clk_sys);
      chk(sel2, 1'b0, "unqualified edge selected");
      bus2.advance_or_load = 1'b1;
      bus2.clock_qualify_n = 1'b0;
      @(negedge clk_sys);
      chk(inv2, 1'b1, "deselected advance not flagged");
      bus2.advance_or_load = 1'b0;
      for (int k = 0; k < 4; k++) begin
         {bus2.chip_select_one_n, bus2.chip_select_two,
          bus2.chip_select_three_n} = 3'h2 ^ (3'h1 << k);
         @(negedge clk_sys);
         chk(sel2, k == 3, "chip select decode");
      end
      wrap_up();
   end
endmodule
`default_nettype wire
